// [rtl/focmd_top.sv]
// How it works
// - Program-once blank-checks, programs, then verifies; complete flag low throughout.
// - Program-once on an already programmed phrase sets access error instead.
// - A phrase holding all ones still counts as blank and may be programmed.
// - Program flash reads are flagged invalid while program-once runs.
// - Program-once access error on slot index not 5, mode, or bad index.
// - Verify error sets first verify bit; uncorrectable error sets the second.
// - Opcode 08 erases all flash and EEPROM, verifies, then releases security if the verify passes.
// - Erase-all access error on slot index not 0 or disallowed mode.
// - Erase-all sets protection violation and skips if anything is protected.
// - Erase-all request input runs the same whole-array erase uncommanded.
// - Request with clock divider not loaded skips erase, sets access error.
// - Divider resets after request-driven erase-all; host reloads before next command.
// - Request erase ignores protection; on pass unsecures and programs security byte.
// - Config pending bit shows the request runs; cleared at completion.
// - Erase-all never changes the protection configuration.
// - Request verify bits collect erase verify and security program verify errors.
// - Opcode 09, slot index 1, erases and verifies the addressed block.
// - Block erase alignment access errors; protection violation if any part protected.
// - Opcode 0A erases the sector; address bits 2..0 nonzero is access error.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module focmd_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// System side
	input wire logic eraseAllReq,
	input wire logic cmdPermitted,
	output logic pflashRdInvalid,
	output logic [6:0] flashClkDiv,
	// Flash array macro
	output focmd_pkg::focmd_arr_req_t arrReq,
	input wire focmd_pkg::focmd_arr_rsp_t arrRsp
);

	// Reset release through two flops
	logic rstSync1_ff;
	logic rstSync2_ff;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstSync1_ff <= 1'b0;
			rstSync2_ff <= 1'b0;
		end else begin
			rstSync1_ff <= 1'b1;
			rstSync2_ff <= rstSync1_ff;
		end
	end
	logic rstN;
	assign rstN = rstSync2_ff;

	// Registers
	logic ccf_ff;
	logic access_error_flag_ff;
	logic protViol_ff;
	logic verErr_ff;
	logic verUnc_ff;
	logic [focmd_pkg::DIV_W-1:0] div_ff;
	logic divLoaded_ff;
	logic [2:0] slotIdx_ff;
	logic [15:0] paramWord_ff [focmd_pkg::NUM_PARAM];
	logic ersPending_ff;
	logic [1:0] sec_ff;
	logic [focmd_pkg::PROT_W-1:0] prot_ff;

	// Bus pipeline
	logic pend_ff;
	logic pendWrite_ff;
	logic [7:0] pendAddr_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;

	// Address phase capture; one wait state so read data can come from a flop
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			pend_ff <= 1'b0;
			pendWrite_ff <= 1'b0;
			pendAddr_ff <= 8'h00;
			hreadyout_ff <= 1'b1;
		end else if (pend_ff) begin
			pend_ff <= 1'b0;
			hreadyout_ff <= 1'b1;
		end else if (hsel && htrans[1] && hready) begin
			pend_ff <= 1'b1;
			pendWrite_ff <= hwrite;
			pendAddr_ff <= {haddr[7:2], 2'b00};
			hreadyout_ff <= 1'b0;
		end
	end

	logic busWr;
	logic busRd;
	assign busWr = pend_ff && pendWrite_ff;
	assign busRd = pend_ff && !pendWrite_ff;

	// Read mux; unmapped offsets read as zero
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		case (pendAddr_ff)
			focmd_pkg::OFS_STATUS: begin
				rdMux[focmd_pkg::STS_CCF] = ccf_ff;
				rdMux[focmd_pkg::STS_ACC] = access_error_flag_ff;
				rdMux[focmd_pkg::STS_PROT] = protViol_ff;
				rdMux[focmd_pkg::STS_VERR] = verErr_ff;
				rdMux[focmd_pkg::STS_VUNC] = verUnc_ff;
			end
			focmd_pkg::OFS_CLKDIV: begin
				rdMux[focmd_pkg::DIV_W-1:0] = div_ff;
				rdMux[focmd_pkg::DIV_LOADED] = divLoaded_ff;
			end
			focmd_pkg::OFS_SLOTIDX: rdMux[2:0] = slotIdx_ff;
			focmd_pkg::OFS_PARAM: begin
				if (slotIdx_ff < 3'(focmd_pkg::NUM_PARAM)) begin
					rdMux[15:0] = paramWord_ff[slotIdx_ff];
				end
			end
			focmd_pkg::OFS_CONFIG: rdMux[focmd_pkg::CFG_ERSPEND] = ersPending_ff;
			focmd_pkg::OFS_SECURITY: rdMux[1:0] = sec_ff;
			focmd_pkg::OFS_PROTECT: rdMux[focmd_pkg::PROT_W-1:0] = prot_ff;
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (busRd) begin
			hrdata_ff <= rdMux;
		end
	end

	// Busy blocks register writes so a running erase cannot be disturbed
	logic regWr;
	assign regWr = busWr && ccf_ff;

	logic launchWr;
	assign launchWr = regWr && (pendAddr_ff == focmd_pkg::OFS_STATUS) &&
		hwdata[focmd_pkg::STS_CCF] && !access_error_flag_ff && !protViol_ff;

	// Launch decode
	logic [7:0] opcode;
	logic [23:0] gAddr;
	logic isPf;
	logic isEe;
	logic launchAcc;
	logic launchProt;
	focmd_pkg::focmd_kind_t launchKind;
	focmd_pkg::focmd_op_t launchOp;
	assign opcode = paramWord_ff[0][15:8];
	assign gAddr = {paramWord_ff[0][7:0], paramWord_ff[1]};
	assign isPf = (gAddr[23:18] == focmd_pkg::PF_HI);
	assign isEe = (gAddr[23:12] == focmd_pkg::EE_HI);

	always_comb begin
		launchAcc = !divLoaded_ff || !cmdPermitted;
		launchProt = 1'b0;
		launchKind = focmd_pkg::K_AREA;
		launchOp = focmd_pkg::OP_NONE;
		case (opcode)
			focmd_pkg::OPC_PROG_ONCE: begin
				launchKind = focmd_pkg::K_ONCE;
				launchOp = focmd_pkg::OP_BLANK_ONCE;
				if (slotIdx_ff != focmd_pkg::IDX_PROG_ONCE ||
					paramWord_ff[1] > focmd_pkg::ONCE_MAX_IDX) begin
					launchAcc = 1'b1;
				end
			end
			focmd_pkg::OPC_ERASE_ALL: begin
				launchKind = focmd_pkg::K_ALL;
				launchOp = focmd_pkg::OP_ERASE_ALL;
				if (slotIdx_ff != focmd_pkg::IDX_ERASE_ALL) begin
					launchAcc = 1'b1;
				end
				launchProt = |prot_ff;
			end
			focmd_pkg::OPC_ERASE_BLK: begin
				launchOp = focmd_pkg::OP_ERASE_BLK;
				if (slotIdx_ff != focmd_pkg::IDX_ERASE_BS || !(isPf || isEe) ||
					(isPf && gAddr[2:0] != 3'h0) || (isEe && gAddr[0])) begin
					launchAcc = 1'b1;
				end
				launchProt = isPf ? |prot_ff[7:0] : prot_ff[focmd_pkg::PROT_EE];
			end
			focmd_pkg::OPC_ERASE_SEC: begin
				launchOp = focmd_pkg::OP_ERASE_SEC;
				if (slotIdx_ff != focmd_pkg::IDX_ERASE_BS || !isPf ||
					gAddr[2:0] != 3'h0) begin
					launchAcc = 1'b1;
				end
				launchProt = prot_ff[gAddr[17:15]];
			end
			default: launchAcc = 1'b1;
		endcase
	end

	// Erase-all request: edge caught and held until the sequencer is idle
	logic reqPrev_ff;
	logic reqLatch_ff;
	logic pinStart;
	focmd_pkg::focmd_state_t state_ff;
	assign pinStart = reqLatch_ff && (state_ff == focmd_pkg::ST_IDLE);
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			reqPrev_ff <= 1'b0;
			reqLatch_ff <= 1'b0;
		end else begin
			reqPrev_ff <= eraseAllReq;
			if (eraseAllReq && !reqPrev_ff) begin
				reqLatch_ff <= 1'b1;
			end else if (pinStart) begin
				reqLatch_ff <= 1'b0;
			end
		end
	end

	// Sequencer
	focmd_pkg::focmd_state_t nxt_state;
	focmd_pkg::focmd_kind_t kind_ff;
	focmd_pkg::focmd_kind_t nxt_kind;
	focmd_pkg::focmd_op_t eraseOp_ff;
	focmd_pkg::focmd_op_t nxt_eraseOp;
	focmd_pkg::focmd_op_t issueOp;
	logic issue;
	logic setAcc;
	logic setProt;
	logic setVErr;
	logic setVUnc;
	logic clrVer;
	logic setCcf;
	logic clrCcf;
	logic setUnsec;
	logic pinDone;

	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_eraseOp = eraseOp_ff;
		issueOp = focmd_pkg::OP_NONE;
		issue = 1'b0;
		setAcc = 1'b0;
		setProt = 1'b0;
		setVErr = 1'b0;
		setVUnc = 1'b0;
		clrVer = 1'b0;
		setCcf = 1'b0;
		clrCcf = 1'b0;
		setUnsec = 1'b0;
		pinDone = 1'b0;
		case (state_ff)
			focmd_pkg::ST_IDLE: begin
				if (pinStart) begin
					if (!divLoaded_ff) begin
						setAcc = 1'b1;
					end else begin
						nxt_kind = focmd_pkg::K_PIN;
						nxt_eraseOp = focmd_pkg::OP_ERASE_ALL;
						issueOp = focmd_pkg::OP_ERASE_ALL;
						issue = 1'b1;
						clrVer = 1'b1;
						clrCcf = 1'b1;
						nxt_state = focmd_pkg::ST_ERASE;
					end
				end else if (launchWr) begin
					clrVer = 1'b1;
					if (launchAcc || launchProt) begin
						setAcc = launchAcc;
						setProt = !launchAcc && launchProt;
					end else begin
						nxt_kind = launchKind;
						nxt_eraseOp = launchOp;
						issueOp = launchOp;
						issue = 1'b1;
						clrCcf = 1'b1;
						nxt_state = (launchKind == focmd_pkg::K_ONCE) ?
							focmd_pkg::ST_BLANK : focmd_pkg::ST_ERASE;
					end
				end
			end
			focmd_pkg::ST_BLANK: begin
				if (arrRsp.done) begin
					if (arrRsp.err) begin
						setAcc = 1'b1;
						nxt_state = focmd_pkg::ST_DONE;
					end else begin
						issueOp = focmd_pkg::OP_PROG_ONCE;
						issue = 1'b1;
						nxt_state = focmd_pkg::ST_PROG;
					end
				end
			end
			focmd_pkg::ST_PROG: begin
				if (arrRsp.done) begin
					issueOp = focmd_pkg::OP_VERIFY_ONCE;
					issue = 1'b1;
					nxt_state = focmd_pkg::ST_VERIFY;
				end
			end
			focmd_pkg::ST_ERASE: begin
				if (arrRsp.done) begin
					issueOp = focmd_pkg::focmd_op_t'(eraseOp_ff + 4'h1);
					issue = 1'b1;
					nxt_state = focmd_pkg::ST_VERIFY;
				end
			end
			focmd_pkg::ST_VERIFY: begin
				if (arrRsp.done) begin
					setVErr = arrRsp.err;
					setVUnc = arrRsp.uncorr;
					nxt_state = focmd_pkg::ST_DONE;
					if (!arrRsp.err && kind_ff == focmd_pkg::K_ALL) begin
						setUnsec = 1'b1;
					end
					if (!arrRsp.err && kind_ff == focmd_pkg::K_PIN) begin
						setUnsec = 1'b1;
						issueOp = focmd_pkg::OP_PROG_SECB;
						issue = 1'b1;
						nxt_state = focmd_pkg::ST_SPROG;
					end
				end
			end
			focmd_pkg::ST_SPROG: begin
				if (arrRsp.done) begin
					issueOp = focmd_pkg::OP_VERIFY_SECB;
					issue = 1'b1;
					nxt_state = focmd_pkg::ST_SVERIFY;
				end
			end
			focmd_pkg::ST_SVERIFY: begin
				if (arrRsp.done) begin
					setVErr = arrRsp.err;
					setVUnc = arrRsp.uncorr;
					nxt_state = focmd_pkg::ST_DONE;
				end
			end
			focmd_pkg::ST_DONE: begin
				setCcf = 1'b1;
				pinDone = (kind_ff == focmd_pkg::K_PIN);
				nxt_state = focmd_pkg::ST_IDLE;
			end
			default: nxt_state = focmd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			state_ff <= focmd_pkg::ST_IDLE;
			kind_ff <= focmd_pkg::K_AREA;
			eraseOp_ff <= focmd_pkg::OP_NONE;
		end else begin
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
			eraseOp_ff <= nxt_eraseOp;
		end
	end

	// Array request: one-cycle strobe; address and data stay with it
	logic [23:0] nxt_arrAddr;
	logic [63:0] nxt_arrData;
	always_comb begin
		nxt_arrAddr = gAddr;
		nxt_arrData = {paramWord_ff[2], paramWord_ff[3], paramWord_ff[4], paramWord_ff[5]};
		if (issueOp == focmd_pkg::OP_PROG_SECB || issueOp == focmd_pkg::OP_VERIFY_SECB) begin
			nxt_arrAddr = focmd_pkg::SEC_BYTE_ADDR;
			nxt_arrData = {56'h0, focmd_pkg::SEC_BYTE_UNSEC};
		end else if (kind_ff == focmd_pkg::K_ONCE || nxt_kind == focmd_pkg::K_ONCE) begin
			nxt_arrAddr = {21'h0, paramWord_ff[1][2:0]};
		end
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			arrReq <= '0;
		end else begin
			arrReq.req <= issue;
			if (issue) begin
				arrReq.op <= issueOp;
				arrReq.addr <= nxt_arrAddr;
				arrReq.data <= nxt_arrData;
			end
		end
	end

	// Program flash reads are invalid for the whole program-once run
	logic pfInv_ff;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			pfInv_ff <= 1'b0;
		end else begin
			pfInv_ff <= (nxt_kind == focmd_pkg::K_ONCE) &&
				(nxt_state != focmd_pkg::ST_IDLE);
		end
	end

	// Status flags; hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ccf_ff <= 1'b1;
			access_error_flag_ff <= 1'b0;
			protViol_ff <= 1'b0;
			verErr_ff <= 1'b0;
			verUnc_ff <= 1'b0;
		end else begin
			if (setCcf) begin
				ccf_ff <= 1'b1;
			end else if (clrCcf) begin
				ccf_ff <= 1'b0;
			end
			if (setAcc) begin
				access_error_flag_ff <= 1'b1;
			end else if (regWr && pendAddr_ff == focmd_pkg::OFS_STATUS &&
				hwdata[focmd_pkg::STS_ACC]) begin
				access_error_flag_ff <= 1'b0;
			end
			if (setProt) begin
				protViol_ff <= 1'b1;
			end else if (regWr && pendAddr_ff == focmd_pkg::OFS_STATUS &&
				hwdata[focmd_pkg::STS_PROT]) begin
				protViol_ff <= 1'b0;
			end
			if (setVErr) begin
				verErr_ff <= 1'b1;
			end else if (clrVer) begin
				verErr_ff <= 1'b0;
			end
			if (setVUnc) begin
				verUnc_ff <= 1'b1;
			end else if (clrVer) begin
				verUnc_ff <= 1'b0;
			end
		end
	end

	// Clock divider: cleared after a request-driven erase-all
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			div_ff <= focmd_pkg::DIV_RESET;
			divLoaded_ff <= 1'b0;
		end else if (pinDone) begin
			div_ff <= focmd_pkg::DIV_RESET;
			divLoaded_ff <= 1'b0;
		end else if (regWr && pendAddr_ff == focmd_pkg::OFS_CLKDIV) begin
			div_ff <= hwdata[focmd_pkg::DIV_W-1:0];
			divLoaded_ff <= 1'b1;
		end
	end

	// Slot index and parameter words
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			slotIdx_ff <= 3'h0;
		end else if (regWr && pendAddr_ff == focmd_pkg::OFS_SLOTIDX) begin
			slotIdx_ff <= hwdata[2:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < focmd_pkg::NUM_PARAM; gi++) begin : gParam
			always_ff @(posedge clk_sys or negedge rstN) begin
				if (!rstN) begin
					paramWord_ff[gi] <= 16'h0000;
				end else if (regWr && pendAddr_ff == focmd_pkg::OFS_PARAM &&
					slotIdx_ff == 3'(gi)) begin
					paramWord_ff[gi] <= hwdata[15:0];
				end
			end
		end
	endgenerate

	// Pending bit tracks a request-driven erase from start to completion
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ersPending_ff <= 1'b0;
		end else if (pinDone) begin
			ersPending_ff <= 1'b0;
		end else if (nxt_kind == focmd_pkg::K_PIN && state_ff == focmd_pkg::ST_IDLE &&
			nxt_state == focmd_pkg::ST_ERASE) begin
			ersPending_ff <= 1'b1;
		end
	end

	// Security field; protection is software-only, no erase path touches it
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			sec_ff <= focmd_pkg::SEC_RESET;
			prot_ff <= focmd_pkg::PROT_RESET;
		end else begin
			if (setUnsec) begin
				sec_ff <= focmd_pkg::SEC_UNSECURE;
			end
			if (regWr && pendAddr_ff == focmd_pkg::OFS_PROTECT) begin
				prot_ff <= hwdata[focmd_pkg::PROT_W-1:0];
			end
		end
	end

	// Outputs
	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign pflashRdInvalid = pfInv_ff;
	assign flashClkDiv = div_ff;

endmodule : focmd_top

// [rtl/focmd_pkg.sv]
package focmd_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CLKDIV = 8'h04;
	localparam logic [7:0] OFS_SLOTIDX = 8'h08;
	localparam logic [7:0] OFS_PARAM = 8'h0C;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam logic [7:0] OFS_SECURITY = 8'h14;
	localparam logic [7:0] OFS_PROTECT = 8'h18;

	// Status register bit positions
	localparam int STS_CCF = 7;
	localparam int STS_ACC = 5;
	localparam int STS_PROT = 4;
	localparam int STS_VERR = 1;
	localparam int STS_VUNC = 0;
	// Clock divider register: value field and loaded flag
	localparam int DIV_W = 7;
	localparam int DIV_LOADED = 7;
	// Config register: erase-all pending bit
	localparam int CFG_ERSPEND = 0;
	// Protect register: bits 7..0 program flash regions, bit 8 EEPROM
	localparam int PROT_EE = 8;
	localparam int PROT_W = 9;

	// Reset values and the unsecured security field value
	localparam logic [1:0] SEC_RESET = 2'h3;
	localparam logic [1:0] SEC_UNSECURE = 2'h2;
	localparam logic [PROT_W-1:0] PROT_RESET = 9'h000;
	localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;

	// Opcodes and the slot index each must leave at launch
	localparam logic [7:0] OPC_PROG_ONCE = 8'h07;
	localparam logic [7:0] OPC_ERASE_ALL = 8'h08;
	localparam logic [7:0] OPC_ERASE_BLK = 8'h09;
	localparam logic [7:0] OPC_ERASE_SEC = 8'h0A;
	localparam logic [2:0] IDX_PROG_ONCE = 3'h5;
	localparam logic [2:0] IDX_ERASE_ALL = 3'h0;
	localparam logic [2:0] IDX_ERASE_BS = 3'h1;
	localparam logic [15:0] ONCE_MAX_IDX = 16'h0007;
	localparam int NUM_PARAM = 6;

	// Global address map
	localparam logic [5:0] PF_HI = 6'h3F;
	localparam logic [11:0] EE_HI = 12'h100;
	localparam logic [23:0] SEC_BYTE_ADDR = 24'hFFFE0F;
	localparam logic [7:0] SEC_BYTE_UNSEC = 8'hFE;

	// Operations requested from the flash array macro
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_BLANK_ONCE = 4'h1,
		OP_PROG_ONCE = 4'h2,
		OP_VERIFY_ONCE = 4'h3,
		OP_ERASE_ALL = 4'h4,
		OP_VERIFY_ALL = 4'h5,
		OP_ERASE_BLK = 4'h6,
		OP_VERIFY_BLK = 4'h7,
		OP_ERASE_SEC = 4'h8,
		OP_VERIFY_SEC = 4'h9,
		OP_PROG_SECB = 4'hA,
		OP_VERIFY_SECB = 4'hB
	} focmd_op_t;

	typedef struct packed {
		logic req;
		focmd_op_t op;
		logic [23:0] addr;
		logic [63:0] data;
	} focmd_arr_req_t;

	typedef struct packed {
		logic done;
		logic err;
		logic uncorr;
	} focmd_arr_rsp_t;

	// Sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_BLANK = 8'h02,
		ST_PROG = 8'h04,
		ST_ERASE = 8'h08,
		ST_VERIFY = 8'h10,
		ST_SPROG = 8'h20,
		ST_SVERIFY = 8'h40,
		ST_DONE = 8'h80
	} focmd_state_t;

	typedef enum logic [1:0] {
		K_ONCE = 2'h0,
		K_ALL = 2'h1,
		K_AREA = 2'h2,
		K_PIN = 2'h3
	} focmd_kind_t;

endpackage : focmd_pkg

// [testbench/focmd_chk.sv]
`timescale 1ns/1ps
module focmd_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Sequencer side
	input wire logic pflashRdInvalid,
	input wire logic [6:0] flashClkDiv,
	input wire focmd_pkg::focmd_arr_req_t arrReq,
	input wire focmd_pkg::focmd_arr_rsp_t arrRsp
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// Bus handshake: one wait cycle, never an error
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("hresp not OKAY");
	property p_wait;
		hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout;
	endproperty
	a_wait: assert property (p_wait) else $error("hreadyout wait wrong");
	// Array requests are single pulses
	property p_pulse;
		arrReq.req |=> !arrReq.req;
	endproperty
	a_pulse: assert property (p_pulse) else $error("array req longer than one cycle");
	// Once sequence keeps program flash reads flagged invalid
	property p_rdinv;
		arrReq.req && arrReq.op inside {focmd_pkg::OP_BLANK_ONCE, focmd_pkg::OP_PROG_ONCE,
			focmd_pkg::OP_VERIFY_ONCE} |-> pflashRdInvalid;
	endproperty
	a_rdinv: assert property (p_rdinv) else $error("reads not flagged invalid");
	property p_once;
		arrRsp.done && !arrRsp.err && arrReq.op == focmd_pkg::OP_BLANK_ONCE
			|=> arrReq.req && arrReq.op == focmd_pkg::OP_PROG_ONCE;
	endproperty
	a_once: assert property (p_once) else $error("blank phrase not programmed");
	// A used phrase must never reach programming
	property p_used;
		arrRsp.done && arrRsp.err && arrReq.op == focmd_pkg::OP_BLANK_ONCE |=> !arrReq.req [*4];
	endproperty
	a_used: assert property (p_used) else $error("used phrase programmed");
	property p_all;
		arrRsp.done && arrReq.op == focmd_pkg::OP_ERASE_ALL
			|=> arrReq.req && arrReq.op == focmd_pkg::OP_VERIFY_ALL;
	endproperty
	a_all: assert property (p_all) else $error("erase-all not verified");
	property p_nosec;
		arrRsp.done && arrRsp.err && arrReq.op == focmd_pkg::OP_VERIFY_ALL |=> !arrReq.req [*4];
	endproperty
	a_nosec: assert property (p_nosec) else $error("security touched after failed verify");
	property p_divclr;
		arrRsp.done && arrReq.op == focmd_pkg::OP_VERIFY_SECB |-> ##[1:4] flashClkDiv == 7'h00;
	endproperty
	a_divclr: assert property (p_divclr) else $error("divider kept after erase-all");
endmodule : focmd_chk

bind focmd_top focmd_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.pflashRdInvalid(pflashRdInvalid), .flashClkDiv(flashClkDiv), .arrReq(arrReq),
	.arrRsp(arrRsp));

// [testbench/test_flash_once_and_erase_commands.sv]
`timescale 1ns/1ps
module test_flash_once_and_erase_commands;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] mask;
		logic [7:0] addr;
	} focmd_note_t;
	// Bus, system and array signals
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic eraseAllReq = 1'b0;
	logic cmdPermitted = 1'b1;
	logic pflashRdInvalid;
	logic [6:0] flashClkDiv;
	focmd_pkg::focmd_arr_req_t arrReq;
	focmd_pkg::focmd_arr_rsp_t arrRsp = '0;
	// Bench state
	int errCount = 0;
	int checked = 0;
	integer seed = 32'h615F;
	int rspCnt = 0;
	logic rdPend = 1'b0;
	logic [63:0] onceMem [8];
	logic [2:0] curPh = 3'h0;
	logic [3:0] errOp = 4'h0;
	logic errUnc = 1'b0;
	logic [31:0] rdata;
	focmd_note_t noteQ[$];
	focmd_pkg::focmd_op_t opQ[$];

	always #2 clk_sys = ~clk_sys;

	focmd_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eraseAllReq(eraseAllReq),
		.cmdPermitted(cmdPermitted), .pflashRdInvalid(pflashRdInvalid),
		.flashClkDiv(flashClkDiv), .arrReq(arrReq), .arrRsp(arrRsp));

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// One AHB single transfer; the wait is bounded so a stuck slave cannot hang us
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		rdata = hrdata;
		cmp("bus wait", 32'h0, 32'(n >= 40));
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		noteQ.push_back('{exp, mask, a});
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic pushOps(input logic [15:0] ops);
		for (int i = 12; i >= 0; i -= 4)
			if (ops[i+:4] != 4'h0) opQ.push_back(focmd_pkg::focmd_op_t'(ops[i+:4]));
	endtask : pushOps

	// Status polled by reads only, no writes while a command runs
	task automatic waitDone();
		int n;
		n = 0;
		do begin
			rd(focmd_pkg::OFS_STATUS, 32'h0, 32'h0);
			n++;
		end while (rdata[7] !== 1'b1 && n < 100);
		cmp("completion wait", 32'h0, 32'(n >= 100));
	endtask : waitDone

	// Access and protection error flags cleared after each run so the next launch starts clean
	task automatic finish(input logic [7:0] st);
		rd(focmd_pkg::OFS_STATUS, {24'h0, st}, 32'hFF);
		bus(1'b1, focmd_pkg::OFS_STATUS, 32'h30);
		cmp("ops left", 32'h0, opQ.size());
	endtask : finish

	task automatic cmd(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] ix,
		input logic [15:0] ops, input logic [7:0] st, input logic ones = 1'b0);
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, focmd_pkg::OFS_SLOTIDX, 32'(i));
			bus(1'b1, focmd_pkg::OFS_PARAM, i == 0 ? w0 : i == 1 ? w1 :
				ones ? 32'hFFFF : $random(seed) & 32'hFFFF);
		end
		bus(1'b1, focmd_pkg::OFS_SLOTIDX, {29'h0, ix});
		curPh = w1[2:0];
		pushOps(ops);
		bus(1'b1, focmd_pkg::OFS_STATUS, 32'h80);
		if (ops != 16'h0) rd(focmd_pkg::OFS_STATUS, 32'h0, 32'h80);
		waitDone();
		finish(st);
	endtask : cmd

	task automatic pin(input logic [15:0] ops, input logic [7:0] st, input logic pend);
		int n;
		n = 0;
		pushOps(ops);
		eraseAllReq <= 1'b1;
		@(posedge clk_sys);
		if (ops != 16'h0)
			do begin
				rd(focmd_pkg::OFS_STATUS, 32'h0, 32'h0);
				n++;
			end while (rdata[7] !== 1'b0 && n < 20);
		if (pend) rd(focmd_pkg::OFS_CONFIG, 32'h1, 32'h1);
		waitDone();
		eraseAllReq <= 1'b0;
		rd(focmd_pkg::OFS_CONFIG, 32'h0, 32'h1);
		finish(st);
	endtask : pin

	task automatic doReset();
		reset_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask : doReset

	task automatic stopTest();
		$display("Comparisons %0d, mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stopTest

	// Read monitor: oldest note pairs with each completed read
	always @(posedge clk_sys) begin
		focmd_note_t nt;
		if (rdPend && hreadyout) begin
			rdPend = 1'b0;
			nt = noteQ.pop_front();
			if (nt.mask != 32'h0) cmp($sformatf("reg %h", nt.addr), nt.exp & nt.mask,
				hrdata & nt.mask);
		end
		if (hsel && htrans[1] && hreadyout && !hwrite) rdPend = 1'b1;
	end

	// Array stand-in; erased once phrases read all ones, random answer delay
	always @(posedge clk_sys) begin
		focmd_pkg::focmd_arr_rsp_t r;
		r = '0;
		if (rspCnt == 1) begin
			r.done = 1'b1;
			r.err = arrReq.op == focmd_pkg::OP_BLANK_ONCE ? onceMem[curPh] !== '1 :
				arrReq.op == errOp;
			r.uncorr = r.err && errUnc && arrReq.op != focmd_pkg::OP_BLANK_ONCE;
		end
		if (rspCnt > 0) rspCnt--;
		if (arrReq.req === 1'b1) begin
			rspCnt = 2 + ($random(seed) & 3);
			if (arrReq.op == focmd_pkg::OP_PROG_ONCE) onceMem[curPh] = arrReq.data;
			cmp("array op", opQ.size() ? 32'(opQ.pop_front()) : 32'hF, 32'(arrReq.op));
		end
		arrRsp <= r;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		errCount++;
		stopTest();
	end

	initial begin
		foreach (onceMem[i]) onceMem[i] = '1;
		doReset();
		rd(focmd_pkg::OFS_STATUS, 32'h80, 32'hFF);
		rd(focmd_pkg::OFS_CONFIG, 32'h0, 32'hFF);
		rd(focmd_pkg::OFS_SECURITY, 32'h3, 32'hFF);
		rd(focmd_pkg::OFS_CLKDIV, 32'h0, 32'hFF);
		rd(focmd_pkg::OFS_PROTECT, 32'h0, 32'h1FF);
		rd(8'h40, 32'h0, 32'hFFFFFFFF);
		pin(16'h0, 8'hA0, 1'b0);
		bus(1'b1, focmd_pkg::OFS_CLKDIV, 32'h5);
		rd(focmd_pkg::OFS_CLKDIV, 32'h85, 32'hFF);
		cmp("divider out", 32'h5, 32'(flashClkDiv));
		cmd(16'h0700, 16'h3, 3'h5, 16'h123, 8'h80);
		cmd(16'h0700, 16'h3, 3'h5, 16'h1, 8'hA0);
		cmd(16'h0700, 16'h5, 3'h5, 16'h123, 8'h80, 1'b1);
		cmd(16'h0700, 16'h5, 3'h5, 16'h123, 8'h80);
		cmd(16'h0700, 16'h2, 3'h4, 16'h0, 8'hA0);
		cmd(16'h0700, 16'h8, 3'h5, 16'h0, 8'hA0);
		cmdPermitted <= 1'b0;
		cmd(16'h0700, 16'h2, 3'h5, 16'h0, 8'hA0);
		cmdPermitted <= 1'b1;
		errOp = 4'h3;
		errUnc = 1'b1;
		cmd(16'h0700, 16'h6, 3'h5, 16'h123, 8'h83);
		errOp = 4'h7;
		errUnc = 1'b0;
		cmd(16'h09FC, 16'h0, 3'h1, 16'h67, 8'h82);
		errOp = 4'h0;
		cmd(16'h0910, 16'h2, 3'h1, 16'h67, 8'h80);
		cmd(16'h0910, 16'h1, 3'h1, 16'h0, 8'hA0);
		cmd(16'h09FC, 16'h4, 3'h1, 16'h0, 8'hA0);
		cmd(16'h09FC, 16'h0, 3'h0, 16'h0, 8'hA0);
		bus(1'b1, focmd_pkg::OFS_PROTECT, 32'h1);
		cmd(16'h09FC, 16'h0, 3'h1, 16'h0, 8'h90);
		cmd(16'h0AFC, 16'h8003, 3'h1, 16'h0, 8'hA0);
		cmd(16'h0AFC, 16'h0, 3'h1, 16'h0, 8'h90);
		cmd(16'h0AFC, 16'h8000, 3'h1, 16'h89, 8'h80);
		cmd(16'h0800, 16'h0, 3'h0, 16'h0, 8'h90);
		bus(1'b1, focmd_pkg::OFS_PROTECT, 32'h100);
		pin(16'h45AB, 8'h80, 1'b1);
		rd(focmd_pkg::OFS_SECURITY, 32'h2, 32'h3);
		rd(focmd_pkg::OFS_CLKDIV, 32'h0, 32'hFF);
		rd(focmd_pkg::OFS_PROTECT, 32'h100, 32'h1FF);
		bus(1'b1, focmd_pkg::OFS_PROTECT, 32'h0);
		doReset();
		rd(focmd_pkg::OFS_SECURITY, 32'h3, 32'h3);
		bus(1'b1, focmd_pkg::OFS_CLKDIV, 32'h5);
		cmd(16'h0800, 16'h0, 3'h1, 16'h0, 8'hA0);
		errOp = 4'h5;
		cmd(16'h0800, 16'h0, 3'h0, 16'h45, 8'h82);
		rd(focmd_pkg::OFS_SECURITY, 32'h3, 32'h3);
		errOp = 4'h0;
		cmd(16'h0800, 16'h0, 3'h0, 16'h45, 8'h80);
		rd(focmd_pkg::OFS_SECURITY, 32'h2, 32'h3);
		errOp = 4'h5;
		pin(16'h45, 8'h82, 1'b0);
		bus(1'b1, focmd_pkg::OFS_CLKDIV, 32'h5);
		errOp = 4'hB;
		errUnc = 1'b1;
		pin(16'h45AB, 8'h83, 1'b0);
		stopTest();
	end
endmodule : test_flash_once_and_erase_commands
